/* src/chgst_regs.vh */
// register addresses, field positions and codes of the charger status bank
`ifndef CHGST_REGS_VH
`define CHGST_REGS_VH

`define CHGST_ADDR_RSVD       8'h09
`define CHGST_ADDR_LIMIT      8'h0A
`define CHGST_ADDR_REGSTAT    8'h0B
`define CHGST_ADDR_SRCSTAT    8'h0C
`define CHGST_ADDR_ZONE       8'h0D

`define CHGST_ZERO_BYTE       8'h00
`define CHGST_ZERO3           3'h0
`define CHGST_ZERO2           2'h0
`define CHGST_ZERO5           5'h00
`define CHGST_ZERO7           7'h00
`define CHGST_ONE3            3'h1

`define CHGST_PHASE_IDLE      3'h0
`define CHGST_PHASE_TRICKLE   3'h1
`define CHGST_PHASE_PRE       3'h2
`define CHGST_PHASE_CC        3'h3
`define CHGST_PHASE_CV        3'h4
`define CHGST_PHASE_TOPOFF    3'h5
`define CHGST_PHASE_DONE      3'h6
`define CHGST_PHASE_RSVD      3'h7

`define CHGST_SRC_NONE        3'h0
`define CHGST_SRC_SDP         3'h1
`define CHGST_SRC_CDP         3'h2
`define CHGST_SRC_ADAPTER     3'h3
`define CHGST_SRC_WEAK        3'h4
`define CHGST_SRC_UNKNOWN     3'h5
`define CHGST_SRC_NONSTD      3'h6
`define CHGST_SRC_RSVD        3'h7

`define CHGST_OPT_OFF         2'h0
`define CHGST_OPT_BUSY        2'h1
`define CHGST_OPT_MAX         2'h2
`define CHGST_OPT_RSVD        2'h3

`define CHGST_ZONE_NORMAL     3'h0
`define CHGST_ZONE_WARM       3'h2
`define CHGST_ZONE_COOL       3'h3
`define CHGST_ZONE_COLD       3'h5
`define CHGST_ZONE_HOT        3'h6

`define CHGST_WEAK_COUNT      3'h7

// positions in the synchronised input bundle
`define CHGST_SY_WIDTH        22
`define CHGST_SY_LIMIT        21:17
`define CHGST_SY_ICR          16
`define CHGST_SY_IVR          15
`define CHGST_SY_THR          14
`define CHGST_SY_WD           13
`define CHGST_SY_PHASE        12:10
`define CHGST_SY_PG           9
`define CHGST_SY_SRC          8:6
`define CHGST_SY_WEAK         5
`define CHGST_SY_OPT          4:3
`define CHGST_SY_ZONE         2:0

// field positions inside the status registers
`define CHGST_BIT_ICR         6
`define CHGST_BIT_IVR         5
`define CHGST_BIT_THR         4
`define CHGST_BIT_WD          3
`define CHGST_FLD_PHASE       2:0
`define CHGST_BIT_PG          7
`define CHGST_FLD_SRC         6:4
`define CHGST_BIT_RSVD_HI     3
`define CHGST_FLD_OPT         2:1
`define CHGST_BIT_RSVD_LO     0

`endif

/* src/chgst_sync.v */
// two-flop synchroniser for a bundle of asynchronous status levels
`timescale 1ns/10ps
module chgst_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rst_b,
    // levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

/* src/chgst_change.v */
// change detector: one-cycle pulse when a synchronised field changes
`timescale 1ns/10ps
module chgst_change #(
    parameter WIDTH = 3
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rst_b,
    // field
    input  wire [WIDTH-1:0] field_in,
    output reg              changed
);
    reg [WIDTH-1:0] last_reg;
    reg             armed_reg;

    // first value after reset is a baseline, not a change
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            last_reg  <= {WIDTH{1'b0}};
            armed_reg <= 1'b0;
            changed   <= 1'b0;
        end else begin
            last_reg  <= field_in;
            armed_reg <= 1'b1;
            changed   <= armed_reg && (field_in != last_reg);
        end
    end
endmodule

/* src/chgst_bank.v */
// read-only charger status register bank, addresses 09h to 0Dh
`timescale 1ns/10ps
`include "chgst_regs.vh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Address 09h and every reserved status bit read as zero.
// - Bits 4:0 at 0Ah give the optimizer limit as 500 mA + n*100 mA.
// - Bit 6 at 0Bh is high while input current regulation is active.
// - Bit 5 at 0Bh is high while input voltage regulation is active.
// - Bit 4 at 0Bh is high while die thermal regulation is active.
// - Bit 3 at 0Bh is high once the bus watchdog has expired.
// - Phase codes 000 idle, 001 trickle, 010 pre-charge, 011 CC.
// - Phase codes 100 CV, 101 top-off, 110 done; 111 is never shown.
// - Bit 7 at 0Ch is high when input power is good.
// - Source codes 000 none, 001 SDP, 010 CDP, 011 adapter.
// - Source 100 after seven weak detections, 101 unknown, 110 other.
// - Optimizer state 00 off, 01 busy, 10 max found; 11 never shown.
// - Zone codes 000 normal, 010 warm, 011 cool, 101 cold, 110 hot.
// - A change of the phase field pulses the phase event output.
// - A change of the source field pulses the source event output.
module chgst_bank (
    // clock and reset
    input  wire       sys_clk,
    input  wire       rst_b,
    // register access port; writes are accepted and dropped
    input  wire       reg_rd,
    input  wire       reg_wr,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_hit,
    // live conditions from the charger (asynchronous)
    input  wire [4:0] optimized_current_limit,
    input  wire       input_current_regulating,
    input  wire       input_voltage_regulating,
    input  wire       thermal_regulating,
    input  wire       watchdog_expired,
    input  wire [2:0] charge_phase,
    input  wire       power_good_status,
    input  wire [2:0] input_source_type,
    input  wire       weak_source,
    input  wire [1:0] optimizer_state,
    input  wire [2:0] thermistor_zone,
    // events to the flag logic
    output reg        charge_phase_event,
    output reg        input_source_event
);
    localparam NSYNC = `CHGST_SY_WIDTH;

    wire [NSYNC-1:0] raw_bus;
    wire [NSYNC-1:0] sy;
    wire             phase_chg;
    wire             src_chg;

    reg  [4:0] limit_reg;
    reg  [6:0] regstat_reg;
    reg  [7:0] srcstat_reg;
    reg  [2:0] zone_reg;
    reg  [2:0] weak_cnt_reg;
    reg  [2:0] weak_cnt_next;
    reg        weak_prev_reg;
    reg  [2:0] src_next;
    reg  [2:0] phase_next;
    reg  [1:0] opt_next;
    reg  [2:0] zone_next;
    reg  [7:0] rdata_next;
    reg        hit_next;

    // synchronised fields, named by what they carry
    wire [4:0] limit_sy;
    wire       icr_sy;
    wire       ivr_sy;
    wire       thr_sy;
    wire       wd_sy;
    wire [2:0] phase_sy;
    wire       pg_sy;
    wire [2:0] src_sy;
    wire       weak_sy;
    wire [1:0] opt_sy;
    wire [2:0] zone_sy;
    wire       weak_rise;

    // register images as the host sees them, reserved bits tied low
    wire [7:0] limit_byte;
    wire [7:0] regstat_byte;
    wire [7:0] srcstat_byte;
    wire [7:0] zone_byte;

    ////////////////////////////////////////////////////////////////////////
    // code legality; each filter below asks one of these
    function phase_legal(input [2:0] code);
        begin
            phase_legal = (code != `CHGST_PHASE_RSVD);
        end
    endfunction

    function opt_legal(input [1:0] code);
        begin
            opt_legal = (code != `CHGST_OPT_RSVD);
        end
    endfunction

    // the weak code is owned by the counter, so a raw input code 100
    // is treated like the reserved one and never copied through
    function src_legal(input [2:0] code);
        begin
            src_legal = (code != `CHGST_SRC_RSVD) &&
                        (code != `CHGST_SRC_WEAK);
        end
    endfunction

    function zone_legal(input [2:0] code);
        begin
            case (code)
                `CHGST_ZONE_NORMAL,
                `CHGST_ZONE_WARM,
                `CHGST_ZONE_COOL,
                `CHGST_ZONE_COLD,
                `CHGST_ZONE_HOT: zone_legal = 1'b1;
                default:         zone_legal = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    assign raw_bus = {optimized_current_limit, input_current_regulating,
                      input_voltage_regulating, thermal_regulating,
                      watchdog_expired, charge_phase, power_good_status,
                      input_source_type, weak_source, optimizer_state,
                      thermistor_zone};

    chgst_sync #(
        .WIDTH    (NSYNC)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in (raw_bus),
        .sync_out (sy)
    );

    // field positions in the bundle follow the order of raw_bus above
    assign limit_sy  = sy[`CHGST_SY_LIMIT];
    assign icr_sy    = sy[`CHGST_SY_ICR];
    assign ivr_sy    = sy[`CHGST_SY_IVR];
    assign thr_sy    = sy[`CHGST_SY_THR];
    assign wd_sy     = sy[`CHGST_SY_WD];
    assign phase_sy  = sy[`CHGST_SY_PHASE];
    assign pg_sy     = sy[`CHGST_SY_PG];
    assign src_sy    = sy[`CHGST_SY_SRC];
    assign weak_sy   = sy[`CHGST_SY_WEAK];
    assign opt_sy    = sy[`CHGST_SY_OPT];
    assign zone_sy   = sy[`CHGST_SY_ZONE];
    // level-sensitive input, so only a fresh rise counts as a detection
    assign weak_rise = weak_sy && !weak_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // filtering of reserved codes: hold the last legal value, since a
    // multi-bit field can pass a reserved code while it changes
    always @* begin
        phase_next = regstat_reg[`CHGST_FLD_PHASE];
        opt_next   = srcstat_reg[`CHGST_FLD_OPT];
        zone_next  = zone_reg;
        if (phase_legal(phase_sy)) begin
            phase_next = phase_sy;
        end
        if (opt_legal(opt_sy)) begin
            opt_next = opt_sy;
        end
        if (zone_legal(zone_sy)) begin
            zone_next = zone_sy;
        end
    end

    // weak source counted on rising edges; reported on the seventh
    always @* begin
        weak_cnt_next = weak_cnt_reg;
        src_next      = srcstat_reg[`CHGST_FLD_SRC];
        if (src_sy == `CHGST_SRC_NONE) begin
            weak_cnt_next = `CHGST_ZERO3;
        end else if (weak_rise && weak_cnt_reg != `CHGST_WEAK_COUNT) begin
            weak_cnt_next = weak_cnt_reg + `CHGST_ONE3;
        end
        // the count saturates, so the weak code stays until the input
        // reports no source and clears it
        if (weak_cnt_next == `CHGST_WEAK_COUNT) begin
            src_next = `CHGST_SRC_WEAK;
        end else if (src_legal(src_sy)) begin
            src_next = src_sy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status capture; the write strobe never reaches these flops
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            limit_reg <= `CHGST_ZERO5;
        end else begin
            limit_reg <= limit_sy;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            regstat_reg <= `CHGST_ZERO7;
        end else begin
            regstat_reg[`CHGST_BIT_ICR]   <= icr_sy;
            regstat_reg[`CHGST_BIT_IVR]   <= ivr_sy;
            regstat_reg[`CHGST_BIT_THR]   <= thr_sy;
            regstat_reg[`CHGST_BIT_WD]    <= wd_sy;
            regstat_reg[`CHGST_FLD_PHASE] <= phase_next;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            srcstat_reg <= `CHGST_ZERO_BYTE;
        end else begin
            srcstat_reg[`CHGST_BIT_PG]      <= pg_sy;
            srcstat_reg[`CHGST_FLD_SRC]     <= src_next;
            srcstat_reg[`CHGST_BIT_RSVD_HI] <= 1'b0;
            srcstat_reg[`CHGST_FLD_OPT]     <= opt_next;
            srcstat_reg[`CHGST_BIT_RSVD_LO] <= 1'b0;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            zone_reg <= `CHGST_ZONE_NORMAL;
        end else begin
            zone_reg <= zone_next;
        end
    end

    // a source that stays weak for good is one detection, not many
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            weak_cnt_reg  <= `CHGST_ZERO3;
            weak_prev_reg <= 1'b0;
        end else begin
            weak_cnt_reg  <= weak_cnt_next;
            weak_prev_reg <= weak_sy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events follow the reported field, so a filtered code makes none
    chgst_change #(
        .WIDTH    (3)
    ) u_phase_chg (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .field_in (regstat_reg[2:0]),
        .changed  (phase_chg)
    );

    chgst_change #(
        .WIDTH    (3)
    ) u_src_chg (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .field_in (srcstat_reg[6:4]),
        .changed  (src_chg)
    );

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            charge_phase_event <= 1'b0;
            input_source_event <= 1'b0;
        end else begin
            charge_phase_event <= phase_chg;
            input_source_event <= src_chg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register images; bits above each field are reserved and read 0
    assign limit_byte   = {`CHGST_ZERO3, limit_reg};
    assign regstat_byte = {1'b0, regstat_reg};
    assign srcstat_byte = srcstat_reg;
    assign zone_byte    = {`CHGST_ZERO5, zone_reg};

    ////////////////////////////////////////////////////////////////////////
    // read decode; writes are accepted and dropped
    always @* begin
        hit_next   = 1'b1;
        rdata_next = `CHGST_ZERO_BYTE;
        case (reg_addr)
            `CHGST_ADDR_RSVD:    rdata_next = `CHGST_ZERO_BYTE;
            `CHGST_ADDR_LIMIT:   rdata_next = limit_byte;
            `CHGST_ADDR_REGSTAT: rdata_next = regstat_byte;
            `CHGST_ADDR_SRCSTAT: rdata_next = srcstat_byte;
            `CHGST_ADDR_ZONE:    rdata_next = zone_byte;
            default:             hit_next   = 1'b0;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata <= `CHGST_ZERO_BYTE;
            reg_hit   <= 1'b0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
            reg_hit   <= hit_next;
        end else if (reg_wr) begin
            reg_hit   <= hit_next;
        end else begin
            reg_hit   <= 1'b0;
        end
    end
endmodule

/* testbench/chgst_bank_props.sv */
// checker of the status bank read port and event outputs
`timescale 1ns/10ps
module chgst_props (
    input wire       sys_clk, rst_b, reg_rd, reg_wr, reg_hit,
    input wire [7:0] reg_addr, reg_rdata,
    input wire [2:0] charge_phase, input_source_type,
    input wire       weak_source, charge_phase_event, input_source_event
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_b);
rsvd_zero_a: assert property (
    reg_rd && reg_addr == 8'h09 |=> reg_rdata == 8'h00 && reg_hit)
    else $error("reserved slot not zero");
limit_field_a: assert property (
    reg_rd && reg_addr == 8'h0A |=> reg_rdata[7:5] == 3'h0)
    else $error("limit register top bits set");
phase_code_a: assert property (
    reg_rd && reg_addr == 8'h0B |=> !reg_rdata[7] && reg_rdata[2:0] != 3'h7)
    else $error("bad status one byte");
source_code_a: assert property (
    reg_rd && reg_addr == 8'h0C |=> reg_rdata[6:4] != 3'h7
        && reg_rdata[2:1] != 2'h3 && !reg_rdata[3] && !reg_rdata[0])
    else $error("bad status two byte");
zone_code_a: assert property (
    reg_rd && reg_addr == 8'h0D |=> reg_rdata[7:3] == 5'h00)
    else $error("zone register top bits set");
unmapped_read_a: assert property (
    reg_rd && (reg_addr < 8'h09 || reg_addr > 8'h0D)
        |=> reg_rdata == 8'h00 && !reg_hit)
    else $error("unmapped read answered");
write_ignored_a: assert property (
    reg_wr && !reg_rd && reg_addr == 8'h0B |=> reg_hit && $stable(reg_rdata))
    else $error("write not ignored");
phase_quiet_a: assert property (
    $stable(charge_phase) [*8] |-> !charge_phase_event)
    else $error("phase event without change");
source_quiet_a: assert property (
    $stable({input_source_type, weak_source}) [*8] |-> !input_source_event)
    else $error("source event without change");
cover property (reg_rd && reg_addr == 8'h0B);
cover property (charge_phase_event);
cover property (input_source_event);
endmodule
bind chgst_bank chgst_props u_props (.sys_clk, .rst_b, .reg_rd, .reg_wr,
    .reg_hit, .reg_addr, .reg_rdata, .charge_phase, .input_source_type,
    .weak_source, .charge_phase_event, .input_source_event);

/* testbench/chgst_host.sv */
// host model issuing single-byte register accesses
`timescale 1ns/10ps
module chgst_host (
    input  wire       sys_clk,
    output reg        reg_rd = 1'b0,
    output reg        reg_wr = 1'b0,
    output reg  [7:0] reg_addr = 8'hA5,
    output reg  [7:0] reg_wdata = 8'h5A,
    input  wire [7:0] reg_rdata,
    input  wire       reg_hit
);
// answer is registered, so it is picked up one cycle after the strobe
task xfer(input wr, input [7:0] a, input [7:0] d,
          output [7:0] q, output h);
    begin
        @(negedge sys_clk);
        reg_rd = !wr;
        reg_wr = wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        // released lines must not keep showing the last value
        reg_addr = ~a;
        reg_wdata = ~d;
        q = reg_rdata;
        h = reg_hit;
    end
endtask
endmodule

/* testbench/charger_status_register_bank_test.sv */
// self-checking bench for the charger status register bank
`timescale 1ns/10ps
module charger_status_register_bank_test;
reg       sys_clk = 1'b0, rst_b = 1'b0, power_good_status = 1'b0;
reg       input_current_regulating = 1'b0, input_voltage_regulating = 1'b0;
reg       thermal_regulating = 1'b0, watchdog_expired = 1'b0;
reg       weak_source = 1'b0;
reg [4:0] optimized_current_limit = 5'h00;
reg [2:0] charge_phase = 3'h0, input_source_type = 3'h0;
reg [2:0] thermistor_zone = 3'h0;
reg [1:0] optimizer_state = 2'h0;
wire       reg_rd, reg_wr, reg_hit, charge_phase_event, input_source_event;
wire [7:0] reg_addr, reg_wdata, reg_rdata;
integer    n_mismatch = 0, checks_done = 0, cyc = 0, i, n_ph, n_src;
reg [7:0]  q, exp_b;
reg        h;
localparam [14:0] ZONES = {3'h6, 3'h5, 3'h3, 3'h2, 3'h0};
chgst_bank DUT (.sys_clk, .rst_b, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_hit, .optimized_current_limit, .input_current_regulating,
    .input_voltage_regulating, .thermal_regulating, .watchdog_expired,
    .charge_phase, .power_good_status, .input_source_type, .weak_source,
    .optimizer_state, .thermistor_zone, .charge_phase_event,
    .input_source_event);
chgst_host host (.sys_clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_hit);
always #50 sys_clk = ~sys_clk;
task conclude;
    begin
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
endtask
// ceiling well above the few hundred cycles the tests need
always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
        n_mismatch = n_mismatch + 1;
        conclude;
    end
end
task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
        checks_done = checks_done + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    end
endtask
task rd(input [7:0] a, input [7:0] e);
    begin
        host.xfer(1'b0, a, 8'h00, q, h);
        chk("rdata", e, q);
        chk("hit", {7'h00, a >= 8'h09 && a <= 8'h0D}, {7'h00, h});
    end
endtask
// inputs pass two sync flops and a capture stage
task settle;
    repeat (4) @(negedge sys_clk);
endtask
task evwin;
    begin
        n_ph = 0;
        n_src = 0;
        repeat (10) @(negedge sys_clk) begin
            n_ph = n_ph + charge_phase_event;
            n_src = n_src + input_source_event;
        end
    end
endtask
task t_access;
    begin
        rd(8'h09, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h0E, 8'h00);
        host.xfer(1'b1, 8'h09, 8'hFF, q, h);
        chk("wr_hit", 8'h01, {7'h00, h});
        rd(8'h09, 8'h00);
        $display("test access done");
    end
endtask
task t_stat1;
    begin
        for (i = 0; i < 7; i = i + 1) begin
            @(negedge sys_clk);
            charge_phase = i[2:0];
            {input_current_regulating, input_voltage_regulating,
             thermal_regulating, watchdog_expired} = 4'h8 >> (i % 4);
            settle;
            exp_b = {1'b0, 4'h8 >> (i % 4), i[2:0]};
            rd(8'h0B, exp_b);
        end
        charge_phase = 3'h7;
        settle;
        rd(8'h0B, 8'h16);
        host.xfer(1'b1, 8'h0B, 8'hFF, q, h);
        rd(8'h0B, 8'h16);
        $display("test status one done");
    end
endtask
task t_stat2;
    begin
        for (i = 0; i < 7; i = i + 1) if (i != 4) begin
            @(negedge sys_clk);
            input_source_type = i[2:0];
            optimizer_state = 2'(i % 3);
            power_good_status = i[0];
            settle;
            exp_b = {i[0], i[2:0], 1'b0, 2'(i % 3), 1'b0};
            rd(8'h0C, exp_b);
        end
        input_source_type = 3'h7;
        optimizer_state = 2'h3;
        settle;
        rd(8'h0C, 8'h60);
        // a raw weak code is never copied through; the last source stays
        input_source_type = 3'h4;
        settle;
        rd(8'h0C, 8'h60);
        input_source_type = 3'h1;
        for (i = 0; i < 7; i = i + 1) begin
            settle;
            rd(8'h0C, 8'h10);
            weak_source = 1'b1;
            settle;
            weak_source = 1'b0;
        end
        settle;
        rd(8'h0C, 8'h40);
        $display("test status two done");
    end
endtask
task t_zone;
    begin
        for (i = 0; i < 5; i = i + 1) begin
            @(negedge sys_clk);
            thermistor_zone = ZONES[3*i +: 3];
            optimized_current_limit = 5'(i * 7);
            settle;
            rd(8'h0D, {5'h00, ZONES[3*i +: 3]});
            rd(8'h0A, 8'(i * 7));
        end
        thermistor_zone = 3'h1;
        settle;
        rd(8'h0D, 8'h06);
        $display("test zone and limit done");
    end
endtask
task t_events;
    begin
        charge_phase = 3'h3;
        evwin;
        chk("phase_ev", 8'h01, n_ph[7:0]);
        charge_phase = 3'h7;
        evwin;
        chk("phase_ev_rsvd", 8'h00, n_ph[7:0]);
        input_source_type = 3'h0;
        evwin;
        chk("src_ev_none", 8'h01, n_src[7:0]);
        input_source_type = 3'h2;
        evwin;
        chk("src_ev", 8'h01, n_src[7:0]);
        chk("phase_ev_quiet", 8'h00, n_ph[7:0]);
        $display("test events done");
    end
endtask
initial begin
    repeat (12) @(negedge sys_clk);
    rst_b = 1'b1;
    t_access;
    t_stat1;
    t_stat2;
    t_zone;
    t_events;
    conclude;
end
endmodule
